/* verilog/adc_serial_lane_framer.sv */
// transmit framer: sample packing, sync characters, scrambling, 8b10b
`timescale 1ns/1ps
`default_nettype none
module adc_serial_lane_framer
  import framer_pkg::*;
#(
  parameter int LATENCY = framer_pkg::BASE_LATENCY
)
(
  // apb slave
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output var  logic [31:0]              prdata,
  output var  logic                     pready,
  output var  logic                     pslverr,
  // converter core
  input  wire logic [11:0]              adc_sample,
  input  wire logic [3:0]               early_estimate,
  input  wire logic [3:0]               power_estimate,
  output var  logic [3:0]               detect_out,
  output var  logic                     output_format_select,
  output var  logic                     external_reference_select,
  // link
  input  wire logic                     sync_req_n,
  output var  framer_pkg::lane_out_type lane_out,
  // four-level straps as comparator codes, two-level pattern pins
  input  wire logic [1:0]               mode_strap_level,
  input  wire logic [1:0]               pin_strap_align_idle,
  input  wire logic [1:0]               pin_strap_lanes_scramble,
  input  wire logic [1:0]               pin_strap_format_ref,
  input  wire logic                     pin_strap_pattern_low,
  input  wire logic                     pin_strap_pattern_high
);
  import framer_pkg::*;

  localparam int DL_DEPTH = LATENCY + DUAL_EXTRA;

  // returns {running disparity out, abcdei fghj}
  function automatic logic [10:0] enc8b10b(input logic [7:0] d,
                                           input logic       k,
                                           input logic       rd);
    logic [5:0] s6;
    logic [3:0] s4;
    logic       r;
    logic       a7;
    s6 = TBL6[d[4:0]];
    if (rd && (($countones(s6) != 3) || (d[4:0] == 5'd7)))
      s6 = ~s6;
    r  = rd ^ ($countones(s6) != 3);
    a7 = (d[7:5] == 3'd7) &&
         (r ? (d[4:0] == 5'd11 || d[4:0] == 5'd13 || d[4:0] == 5'd14)
            : (d[4:0] == 5'd17 || d[4:0] == 5'd18 || d[4:0] == 5'd20));
    s4 = a7 ? ALT7 : TBL4[d[7:5]];
    if (r && (($countones(s4) != 2) || (d[7:5] == 3'd3)))
      s4 = ~s4;
    r = r ^ ($countones(s4) != 2);
    if (k)
      enc8b10b = (d == OCT_K287) ? {rd, rd ? K287_RDP : K287_RDN}
                                 : {~rd, rd ? K285_RDP : K285_RDN};
    else
      enc8b10b = {r, s6, s4};
  endfunction

  // self-synchronous scrambler 1+x^14+x^15, msb first; {state, octet}
  function automatic logic [22:0] scramble8(input logic [7:0]  d,
                                            input logic [14:0] st);
    logic [14:0] s;
    logic [7:0]  o;
    s = st;
    o = 8'h00;
    for (int i = 7; i >= 0; i--)
    begin
      o[i] = d[i] ^ s[13] ^ s[14];
      s    = {s[13:0], o[i]};
    end
    scramble8 = {s, o};
  endfunction

  // input synchronisers
  logic        sync_s1_r;
  logic        sync_s2_r;
  logic [9:0]  strap_s1_r;
  logic [9:0]  strap_s2_r;
  logic [SYNC_ON_TAP:0] act_sh_r;

  // state
  logic [6:0]            ctrl_r;
  logic [SAMPLE_W-1:0]   dl_r [DL_DEPTH];
  logic                  rd0_r;
  logic                  rd1_r;
  logic [14:0]           scr0_r;
  logic [14:0]           scr1_r;
  logic [14:0]           prbs_r;
  logic [7:0]            prev0_r;
  logic [7:0]            prev1_r;
  logic                  alt_r;
  logic                  send_sync_r;
  logic [15:0]           raw_r;
  logic [4:0]            up_cnt_r;

  wire logic [9:0] strap_raw = {mode_strap_level, pin_strap_align_idle,
                                pin_strap_lanes_scramble,
                                pin_strap_format_ref,
                                pin_strap_pattern_high,
                                pin_strap_pattern_low};

  // strap decode
  wire logic [1:0] lvl_mode = strap_s2_r[9:8];
  wire logic [1:0] lvl_ai   = strap_s2_r[7:6];
  wire logic [1:0] lvl_ls   = strap_s2_r[5:4];
  wire logic [1:0] lvl_fr   = strap_s2_r[3:2];
  wire logic       par_mode = (lvl_mode == STRAP_LVL_PAR);
  wire logic       pattern_select_0 = strap_s2_r[0];
  wire logic       pattern_select_1 = strap_s2_r[1];

  cfg_type strap_cfg;
  cfg_type cfg;
  assign strap_cfg.frame_align_replace = lvl_ai[1] ^ lvl_ai[0];
  assign strap_cfg.idle_char_select    = lvl_ai[1];
  assign strap_cfg.lane_split_select   = lvl_ls[1] ^ lvl_ls[0];
  assign strap_cfg.scramble_enable     = lvl_ls[1];
  assign strap_cfg.pattern_select      =
    pattern_type'({pattern_select_1, pattern_select_0});
  assign strap_cfg.detect_power_select = 1'b0;
  assign cfg = par_mode ? strap_cfg : cfg_type'(ctrl_r);

  // sync request, in force from tap ON and out from tap OFF
  wire logic sync_mode = act_sh_r[SYNC_ON_TAP] &
                         act_sh_r[SYNC_OFF_TAP];

  // sample path
  wire logic       dual = cfg.lane_split_select;
  wire logic [SAMPLE_W-1:0] samp_fmt = output_format_select ? adc_sample
    : {~adc_sample[SAMPLE_W-1], adc_sample[SAMPLE_W-2:0]};
  wire logic [SAMPLE_W-1:0] tap_word = dual ? dl_r[DL_DEPTH-1]
                                            : dl_r[LATENCY-1];
  wire logic [15:0] data_word = {tap_word, {PAD_W{1'b0}}};

  wire logic [22:0] prbs_a = scramble8(8'h00, prbs_r);
  wire logic [22:0] prbs_b = scramble8(8'h00, prbs_a[22:8]);
  wire logic [15:0] src_word =
    (cfg.pattern_select == PAT_ADC) ? data_word :
    (cfg.pattern_select == PAT_B5)  ? WORD_B5B5 :
    (cfg.pattern_select == PAT_FF)  ? WORD_FF00 :
                                      {prbs_a[7:0], prbs_b[7:0]};

  // scrambling; the random pattern bypasses it
  wire logic use_scramble = cfg.scramble_enable &&
                            (cfg.pattern_select != PAT_PRBS);
  wire logic [22:0] sc_a = scramble8(src_word[15:8], scr0_r);
  wire logic [22:0] sc_b = scramble8(src_word[7:0],
                                     dual ? scr1_r : sc_a[22:8]);
  wire logic [7:0] oa = use_scramble ? sc_a[7:0] : src_word[15:8];
  wire logic [7:0] ob = use_scramble ? sc_b[7:0] : src_word[7:0];

  // last octet of a frame repeated: lane0 in dual, second slot always
  wire logic rep0 = cfg.frame_align_replace && dual &&
                    (oa == prev0_r);
  wire logic rep1 = cfg.frame_align_replace &&
                    (ob == (dual ? prev1_r : prev0_r));

  // idle characters: second slot or alternate frames carry D chars
  wire logic sk0 = !(cfg.idle_char_select && dual && alt_r);
  wire logic sk1 = !(cfg.idle_char_select && (!dual || alt_r));

  wire logic [7:0]  c0 = sync_mode ? (sk0 ? OCT_K285
                                          : (rd0_r ? OCT_D162 : OCT_D56))
                                   : (rep0 ? OCT_K287 : oa);
  wire logic        k0 = sync_mode ? sk0 : rep0;
  wire logic [10:0] e0 = enc8b10b(c0, k0, rd0_r);
  wire logic        rd_in1 = dual ? rd1_r : e0[10];
  wire logic [7:0]  c1 = sync_mode ? (sk1 ? OCT_K285
                                          : (rd_in1 ? OCT_D162 : OCT_D56))
                                   : (rep1 ? OCT_K287 : ob);
  wire logic        k1 = sync_mode ? sk1 : rep1;
  wire logic [10:0] e1 = enc8b10b(c1, k1, rd_in1);

  // apb decode
  wire logic setup     = psel & ~penable;
  wire logic hit_ctrl  = (paddr == CTRL_OFS);
  wire logic hit_stat  = (paddr == STATUS_OFS);
  wire logic wr_ctrl   = psel & penable & pready & pwrite & hit_ctrl &
                         pstrb[0];
  wire logic [31:0] status_word = {19'h00000, external_reference_select,
                                   output_format_select, ~sync_s2_r,
                                   send_sync_r, par_mode, 1'b0, cfg};
  wire logic [31:0] rd_mux = hit_ctrl ? {25'h0000000, ctrl_r}
                           : hit_stat ? status_word : 32'h00000000;

  // synchronisers and request line; sampled on the internal clock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_s1_r  <= 1'b1;
      sync_s2_r  <= 1'b1;
      strap_s1_r <= 10'h000;
      strap_s2_r <= 10'h000;
      act_sh_r   <= '0;
    end
    else
    begin
      sync_s1_r  <= sync_req_n;
      sync_s2_r  <= sync_s1_r;
      strap_s1_r <= strap_raw;
      strap_s2_r <= strap_s1_r;
      act_sh_r   <= {act_sh_r[SYNC_ON_TAP-1:0], ~sync_s2_r};
    end
  end

  // sample delay line
  genvar gi;
  generate
    for (gi = 0; gi < DL_DEPTH; gi++)
    begin : g_dl
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          dl_r[gi] <= '0;
        else if (gi == 0)
          dl_r[gi] <= samp_fmt;
        else
          dl_r[gi] <= dl_r[(gi == 0) ? 0 : gi - 1];
      end
    end
  endgenerate

  // encoder state and lane outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lane_out    <= '0;
      rd0_r       <= 1'b0;
      rd1_r       <= 1'b0;
      scr0_r      <= SCRAMBLE_SEED;
      scr1_r      <= SCRAMBLE_SEED;
      prbs_r      <= SCRAMBLE_SEED;
      prev0_r     <= 8'h00;
      prev1_r     <= 8'h00;
      alt_r       <= 1'b0;
      send_sync_r <= 1'b0;
      raw_r       <= 16'h0000;
    end
    else
    begin
      lane_out.lane1_enable <= dual;
      lane_out.lane0_code   <= dual ? {e0[9:0], 10'h000}
                                    : {e0[9:0], e1[9:0]};
      lane_out.lane1_code   <= dual ? e1[9:0] : 10'h000;
      rd0_r       <= dual ? e0[10] : e1[10];
      rd1_r       <= dual ? e1[10] : rd1_r;
      prbs_r      <= prbs_b[22:8];
      alt_r       <= sync_mode ? ~alt_r : 1'b0;
      send_sync_r <= sync_mode;
      raw_r       <= src_word;
      if (!sync_mode && use_scramble)
      begin
        scr0_r <= dual ? sc_a[22:8] : sc_b[22:8];
        scr1_r <= dual ? sc_b[22:8] : scr1_r;
      end
      if (!sync_mode)
      begin
        prev0_r <= dual ? oa : ob;
        prev1_r <= dual ? ob : prev1_r;
      end
    end
  end

  // analog-side controls and detect outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      output_format_select      <= 1'b0;
      external_reference_select <= 1'b0;
      detect_out                <= 4'h0;
    end
    else
    begin
      output_format_select      <= lvl_fr[1];
      external_reference_select <= lvl_fr[1] ^ lvl_fr[0];
      detect_out <= cfg.detect_power_select ? power_estimate
                                            : early_estimate;
    end
  end

  // apb slave, one wait-free access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r  <= CTRL_RESET;
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= setup;
      prdata  <= (setup & ~pwrite) ? rd_mux : 32'h00000000;
      pslverr <= setup & (~(hit_ctrl | hit_stat) | (pwrite & hit_stat));
      if (wr_ctrl)
        ctrl_r <= pwdata[6:0];
    end
  end

  // run time since reset, for the checks below
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      up_cnt_r <= 5'h00;
    else if (up_cnt_r != 5'h1f)
      up_cnt_r <= up_cnt_r + 5'h01;
  end

  wire logic hi_k285 = (lane_out.lane0_code[19:10] == K285_RDN) ||
                       (lane_out.lane0_code[19:10] == K285_RDP);
  wire logic lo_k287 = (lane_out.lane0_code[9:0] == K287_RDN) ||
                       (lane_out.lane0_code[9:0] == K287_RDP);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sync_on_a: assert property (
    $fell(sync_s2_r) ##1 !sync_s2_r [*8] |=> hi_k285)
    else $error("sync characters late after request");
  sync_off_a: assert property (
    $rose(sync_s2_r) && act_sh_r == '1 |-> ##7 send_sync_r ##1 !send_sync_r)
    else $error("data not back eight clocks after release");
  sync_hold_a: assert property (
    !sync_s2_r [*8] ##1 !sync_s2_r |=> send_sync_r)
    else $error("sync characters stopped while request low");
  lat_single_a: assert property (
    up_cnt_r > 5'd23 &&
    $past(cfg.pattern_select == PAT_ADC && !cfg.lane_split_select)
    |-> raw_r[14:4] == $past(adc_sample[10:0], 21) && raw_r[3:0] == 4'h0)
    else $error("single lane sample latency wrong");
  lat_dual_a: assert property (
    up_cnt_r > 5'd23 &&
    $past(cfg.pattern_select == PAT_ADC && cfg.lane_split_select)
    |-> raw_r[14:4] == $past(adc_sample[10:0], 22))
    else $error("dual lane sample latency wrong");
  align_repl_a: assert property (
    $past(!sync_mode && !use_scramble && !cfg.lane_split_select) &&
    $past(!sync_mode && !use_scramble && !cfg.lane_split_select, 2) &&
    raw_r[7:0] == $past(raw_r[7:0])
    |-> lo_k287 == $past(cfg.frame_align_replace))
    else $error("repeated last octet handled wrongly");
  split_a: assert property (
    cfg.lane_split_select |=> lane_out.lane1_enable &&
                              lane_out.lane0_code[9:0] == 10'h000)
    else $error("dual lane output layout wrong");
  pattern_a: assert property (
    $past(cfg.pattern_select == PAT_B5 || cfg.pattern_select == PAT_FF)
    |-> raw_r == (($past(cfg.pattern_select) == PAT_B5) ? WORD_B5B5
                                                        : WORD_FF00))
    else $error("test pattern word wrong");
  detect_a: assert property (
    par_mode |=> detect_out == $past(early_estimate))
    else $error("detect outputs not early estimate in pin mode");
  disp_a: assert property (
    up_cnt_r > 5'd1 |-> $countones(lane_out.lane0_code[19:10]) inside {4, 5, 6})
    else $error("code group disparity out of range");

  strap_a: assert property (
    par_mode |-> cfg.idle_char_select == lvl_ai[1] &&
                 cfg.frame_align_replace == (lvl_ai != 2'h0 && lvl_ai != 2'h3))
    else $error("align and idle strap decoded wrongly");

endmodule
`default_nettype wire

/* verilog/framer_pkg.sv */
// constants and types shared by the serial lane framer
package framer_pkg;

  // sample and frame layout
  localparam int SAMPLE_W = 12;
  localparam int PAD_W    = 4;

  // latencies in sample clocks
  localparam int BASE_LATENCY     = 20;
  localparam int DUAL_EXTRA       = 1;
  localparam int SYNC_ON_LATENCY  = 9;
  localparam int SYNC_OFF_LATENCY = 8;
  // taps of the request shift line: sync stage and output stage take two
  localparam int SYNC_ON_TAP      = SYNC_ON_LATENCY - 2;
  localparam int SYNC_OFF_TAP     = SYNC_OFF_LATENCY - 2;

  // register offsets and reset values
  localparam logic [7:0]  CTRL_OFS    = 8'h00;
  localparam logic [7:0]  STATUS_OFS  = 8'h04;
  localparam logic [6:0]  CTRL_RESET  = 7'h00;

  // strap level that selects parallel pin control
  localparam logic [1:0]  STRAP_LVL_PAR = 2'h2;

  // characters
  localparam logic [7:0]  OCT_K285 = 8'hbc;
  localparam logic [7:0]  OCT_K287 = 8'hfc;
  localparam logic [7:0]  OCT_D56  = 8'hc5;
  localparam logic [7:0]  OCT_D162 = 8'h50;
  localparam logic [9:0]  K285_RDN = 10'h0fa;
  localparam logic [9:0]  K285_RDP = 10'h305;
  localparam logic [9:0]  K287_RDN = 10'h0f8;
  localparam logic [9:0]  K287_RDP = 10'h307;

  // test words and scrambler seed
  localparam logic [15:0] WORD_B5B5 = 16'hb5b5;
  localparam logic [15:0] WORD_FF00 = 16'hff00;
  localparam logic [14:0] SCRAMBLE_SEED = 15'h7fff;

  // 5b/6b and 3b/4b codes, negative running disparity
  localparam logic [5:0] TBL6 [32] = '{
    6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
    6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
  localparam logic [3:0] TBL4 [8] = '{
    4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
  localparam logic [3:0] ALT7 = 4'h7;

  typedef enum logic [1:0] {
    PAT_ADC  = 2'b00,
    PAT_B5   = 2'b01,
    PAT_FF   = 2'b10,
    PAT_PRBS = 2'b11
  } pattern_type;

  // layout equals the control register, bit 6 first
  typedef struct packed {
    logic        detect_power_select;
    pattern_type pattern_select;
    logic        scramble_enable;
    logic        lane_split_select;
    logic        idle_char_select;
    logic        frame_align_replace;
  } cfg_type;

  typedef struct packed {
    logic        lane1_enable;
    logic [19:0] lane0_code;
    logic [9:0]  lane1_code;
  } lane_out_type;

endpackage

/* tb/link_receiver.sv */
// receiver model: drives the synchronisation request pin
`timescale 1ns/1ps
`default_nettype none
module link_receiver
  import framer_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // bench command and request pin
  input  wire logic sync_cmd,
  output var  logic sync_req_n
);
  // request held low for as long as the bench asks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync_req_n <= 1'b1;
    else
      sync_req_n <= ~sync_cmd;
  end
endmodule
`default_nettype wire

/* tb/adc_serial_lane_framer_test.sv */
// self-checking bench for the serial lane framer
`timescale 1ns/1ps
`default_nettype none
module adc_serial_lane_framer_test;
  import framer_pkg::*;
  logic         pclk = 1'b0;
  logic         presetn = 1'b0;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [7:0]   paddr = 8'h00;
  logic [31:0]  pwdata = 32'h0;
  logic [3:0]   pstrb = 4'hf;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic [11:0]  adc_sample = 12'h000;
  logic [3:0]   early_estimate = 4'h5;
  logic [3:0]   power_estimate = 4'ha;
  logic [3:0]   detect_out;
  logic         output_format_select;
  logic         external_reference_select;
  logic         sync_cmd = 1'b0;
  logic         sync_req_n;
  lane_out_type lane_out;
  logic [1:0]   mode_strap_level = 2'h0;
  logic [1:0]   pin_strap_align_idle = 2'h0;
  logic [1:0]   pin_strap_lanes_scramble = 2'h0;
  logic [1:0]   pin_strap_format_ref = 2'h0;
  logic         pin_strap_pattern_low = 1'b0;
  logic         pin_strap_pattern_high = 1'b0;
  logic [31:0]  rd;
  logic         err;
  int           n_fail = 0;
  int           check_count = 0;

  adc_serial_lane_framer #(.LATENCY(BASE_LATENCY)) u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .adc_sample, .early_estimate,
    .power_estimate, .detect_out, .output_format_select,
    .external_reference_select, .sync_req_n, .lane_out,
    .mode_strap_level, .pin_strap_align_idle, .pin_strap_lanes_scramble,
    .pin_strap_format_ref, .pin_strap_pattern_low, .pin_strap_pattern_high);
  link_receiver u_rx (.pclk, .presetn, .sync_cmd, .sync_req_n);

  always #20 pclk = ~pclk;

  // code group of an octet for the given running disparity
  function automatic logic [9:0] enc(input logic [7:0] x, input logic r);
    logic [5:0] s6;
    logic [3:0] s4;
    logic       alt;
    s6 = TBL6[x[4:0]];
    if (r && ($countones(s6) != 3 || x[4:0] == 5'h07))
      s6 = ~s6;
    if ($countones(s6) != 3)
      r = ~r;
    alt = r ? (x[4:0] inside {5'h0b, 5'h0d, 5'h0e})
            : (x[4:0] inside {5'h11, 5'h12, 5'h14});
    s4 = (x[7:5] == 3'h7 && alt) ? ALT7 : TBL4[x[7:5]];
    if (r && ($countones(s4) != 2 || x[7:5] == 3'h3))
      s4 = ~s4;
    return {s6, s4};
  endfunction
  function automatic logic ok(input logic [9:0] c, input logic [7:0] x);
    return c === enc(x, 1'b0) || c === enc(x, 1'b1);
  endfunction
  function automatic logic kc(input logic [9:0] c);
    return c === K285_RDN || c === K285_RDP;
  endfunction
  function automatic logic [11:0] smp(input int i);
    return 12'(i * 37 + 11);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (n_fail == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // wait for the slave; only the watchdog ends a hang
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cfg(input logic [31:0] v);
    apb(1'b1, CTRL_OFS, v);
  endtask
  // stream a sample ramp and compare frames after the latency
  task automatic run(input int lat, input logic dual);
    logic [11:0] s;
    logic [9:0]  g;
    logic [9:0]  h;
    for (int j = 0; j < 50; j++)
    begin
      @(posedge pclk);
      adc_sample <= smp(j);
      #1;
      // format strap low: two's complement, msb inverted
      s = smp(j - lat - 1) ^ 12'h800;
      g = dual ? lane_out.lane1_code : lane_out.lane0_code[9:0];
      h = lane_out.lane0_code[19:10];
      if (j > lat)
      begin
        chk(32'(ok(h, s[11:4])), 32'h1);
        chk(32'(ok(g, {s[3:0], 4'h0})), 32'h1);
        chk(32'(lane_out.lane1_enable), 32'(dual));
        g = dual ? lane_out.lane0_code[9:0] : lane_out.lane1_code;
        chk(32'(g), 32'h0);
      end
    end
  endtask
  task automatic sync_test(input logic idle);
    logic [9:0] g;
    cfg({30'h0, idle, 1'b0});
    @(posedge pclk);
    sync_cmd <= 1'b1;
    for (int k = 1; k < 41; k++)
    begin
      @(posedge pclk);
      #1;
      g = lane_out.lane0_code[9:0];
      if (k == 11)
        chk(32'(kc(lane_out.lane0_code[19:10])), 32'h0);
      if (k > 11)
      begin
        chk(32'(kc(lane_out.lane0_code[19:10])), 32'h1);
        chk(32'(idle ? ok(g, OCT_D56) || ok(g, OCT_D162) : kc(g)),
            32'h1);
      end
    end
    @(posedge pclk);
    sync_cmd <= 1'b0;
    for (int k = 1; k < 12; k++)
    begin
      @(posedge pclk);
      #1;
      if (k > 9)
        chk(32'(kc(lane_out.lane0_code[19:10])), 32'(k == 10));
    end
  endtask
  task automatic pat(input logic [31:0] v, input logic [7:0] hi,
                     input logic [7:0] lo, input logic fa);
    logic [9:0] g;
    cfg(v);
    repeat (30) @(posedge pclk);
    #1;
    g = lane_out.lane0_code[9:0];
    chk(32'(ok(lane_out.lane0_code[19:10], hi)), 32'h1);
    chk(32'(fa ? g inside {K287_RDN, K287_RDP} : ok(g, lo)),
        32'h1);
  endtask

  initial
  begin
    #400000;
    n_fail++;
    tally_and_finish();
  end

  initial
  begin
    int         hits;
    logic [1:0] gr;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(rd, 32'(CTRL_RESET));
    cfg(32'h7f);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(rd, 32'h7f);
    apb(1'b0, 8'h08, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b1, STATUS_OFS, 32'h1);
    chk(32'(err), 32'h1);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(32'(rd[8]), 32'h0);
    cfg(32'h0);
    run(BASE_LATENCY, 1'b0);
    cfg(32'h4);
    run(BASE_LATENCY + DUAL_EXTRA, 1'b1);
    sync_test(1'b0);
    sync_test(1'b1);
    pat(32'h10, 8'hb5, 8'hb5, 1'b0);
    pat(32'h11, 8'hb5, 8'hb5, 1'b1);
    pat(32'h20, 8'hff, 8'h00, 1'b0);
    cfg(32'h8);
    @(posedge pclk);
    adc_sample <= 12'h5a3;
    repeat (30) @(posedge pclk);
    hits = 0;
    repeat (16)
    begin
      @(posedge pclk);
      #1;
      // unscrambled first octet would be 8'hda (msb inverted)
      hits += ok(lane_out.lane0_code[19:10], 8'hda);
    end
    chk(32'(hits < 16), 32'h1);
    pat(32'h0, 8'hda, 8'h30, 1'b0);
    cfg(32'h40);
    repeat (3) @(posedge pclk);
    #1;
    chk(32'(detect_out), 32'(power_estimate));
    @(posedge pclk);
    mode_strap_level <= STRAP_LVL_PAR;
    for (int i = 0; i < 4; i++)
    begin
      gr = 2'(i) ^ 2'(i >> 1);
      @(posedge pclk);
      pin_strap_align_idle <= 2'(i);
      pin_strap_lanes_scramble <= 2'(i);
      pin_strap_format_ref <= 2'(i);
      {pin_strap_pattern_high, pin_strap_pattern_low} <= 2'(i);
      repeat (4) @(posedge pclk);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk(32'(rd[5:0]), 32'({2'(i), gr, gr}));
      chk(32'(rd[8]), 32'h1);
      chk(32'({output_format_select, external_reference_select}),
          32'(gr));
      chk(32'(detect_out), 32'(early_estimate));
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
